// ---- tdc_timer.sv ----
// Dual 8-bit timer/event counter with APB register access
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "tdc_regs.svh"

module tdc_timer #(
	parameter int PRE_W = 11
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [5:0]  port_in,
	output logic      [5:0]  port_out,
	output logic      [5:0]  port_oe_n,
	output logic      [1:0]  match_irq
);
	import tdc_pkg::*;

	// ------------------------------------------------------------
	// Registers and bus decode
	// ------------------------------------------------------------
	tdc_mode_t [1:0]       mode;
	logic [1:0][2:0]       csel;
	tdc_byte_t [1:0]       cmp;
	tdc_byte_t [1:0]       cnt;
	tdc_byte_t             pdir;
	tdc_byte_t             plat;
	logic [1:0]            tff;
	logic [1:0]            pwm_act;
	logic [1:0][PRE_W-1:0] pre;
	logic [1:0]            tick_raw;
	logic [1:0]            tick;
	logic [1:0]            run_eff;
	logic [1:0]            step;
	logic [1:0]            clr_m;
	logic [1:0]            fire;
	logic [1:0]            lvl;
	logic [1:0]            wr_mode;
	logic [1:0]            ev_s1;
	logic [1:0]            ev_s2;
	logic [1:0]            ev_s3;
	logic                  casc;
	logic                  m16;
	logic                  setup;
	logic                  wr_go;
	tdc_byte_t             rd_val;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	function automatic logic addr_hit(input logic [15:0] a);
		case (a)
			`TDC_MODE0_ADDR, `TDC_MODE1_ADDR, `TDC_CSEL0_ADDR,
			`TDC_CSEL1_ADDR, `TDC_CMP0_ADDR, `TDC_CMP1_ADDR,
			`TDC_CNT0_ADDR, `TDC_CNT1_ADDR, `TDC_PDIR_ADDR,
			`TDC_PLAT_ADDR: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	endfunction
	// Low bits of the prescaler that must all be one for a tick
	function automatic logic [PRE_W-1:0] div_mask(
		input logic [2:0] sel,
		input logic       odd
	);
		logic [3:0] e;
		e = {sel - 3'h2, 1'b0} + {3'h0, odd};
		div_mask = '0;
		for (int b = 0; b < PRE_W; b++) begin
			div_mask[b] = (b < int'(e));
		end
	endfunction
	assign setup   = psel & ~penable;
	assign wr_go   = psel & penable & pwrite & pready;
	assign wr_mode = {wr_go & (paddr == `TDC_MODE1_ADDR),
	                  wr_go & (paddr == `TDC_MODE0_ADDR)};
	assign casc    = mode[1].casc;
	assign m16     = {cnt[1], cnt[0]} == {cmp[1], cmp[0]};
	always_comb begin
		case (paddr)
			`TDC_MODE0_ADDR: rd_val = {mode[0].run, mode[0].pwm, 4'h0,
			                           mode[0].pol, mode[0].oe};
			`TDC_MODE1_ADDR: rd_val = {mode[1].run, mode[1].pwm, 1'b0,
			                           mode[1].casc, 2'b00,
			                           mode[1].pol, mode[1].oe};
			`TDC_CSEL0_ADDR: rd_val = {5'h00, csel[0]};
			`TDC_CSEL1_ADDR: rd_val = {5'h00, csel[1]};
			`TDC_CMP0_ADDR:  rd_val = cmp[0];
			`TDC_CMP1_ADDR:  rd_val = cmp[1];
			`TDC_CNT0_ADDR:  rd_val = cnt[0];
			`TDC_CNT1_ADDR:  rd_val = cnt[1];
			`TDC_PDIR_ADDR:  rd_val = pdir | `TDC_PDIR_ONES;
			`TDC_PLAT_ADDR:  rd_val = plat;
			default:         rd_val = 8'h00;
		endcase
	end
	// Answer in the first access cycle; data captured at setup
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~addr_hit(paddr);
			if (setup) begin
				prdata <= {24'h00_0000, rd_val};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mode <= {`TDC_MODE_RST, `TDC_MODE_RST};
			csel <= {`TDC_CSEL_RST, `TDC_CSEL_RST};
			cmp  <= {`TDC_CMP_RST, `TDC_CMP_RST};
			pdir <= `TDC_PDIR_RST;
			plat <= `TDC_PLAT_RST;
		end else if (wr_go) begin
			case (paddr)
				`TDC_MODE0_ADDR: mode[0] <= '{pwdata[`TDC_RUN_BIT],
				                  pwdata[`TDC_PWM_BIT], 1'b0,
				                  pwdata[`TDC_POL_BIT], pwdata[`TDC_OE_BIT]};
				`TDC_MODE1_ADDR: mode[1] <= '{pwdata[`TDC_RUN_BIT],
				                  pwdata[`TDC_PWM_BIT],
				                  pwdata[`TDC_CASC_BIT],
				                  pwdata[`TDC_POL_BIT], pwdata[`TDC_OE_BIT]};
				`TDC_CSEL0_ADDR: csel[0] <= pwdata[2:0];
				`TDC_CSEL1_ADDR: csel[1] <= pwdata[2:0];
				`TDC_CMP0_ADDR:  cmp[0]  <= pwdata[7:0];
				`TDC_CMP1_ADDR:  cmp[1]  <= pwdata[7:0];
				`TDC_PDIR_ADDR:  pdir    <= pwdata[7:0];
				`TDC_PLAT_ADDR:  plat    <= pwdata[7:0];
				default: ;
			endcase
		end
	end
	// ------------------------------------------------------------
	// Event pin synchroniser
	// ------------------------------------------------------------
	// Third stage only feeds the edge detector, never the first stage
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ev_s1 <= 2'b00;
			ev_s2 <= 2'b00;
			ev_s3 <= 2'b00;
		end else begin
			ev_s1 <= port_in[3:2];
			ev_s2 <= ev_s1;
			ev_s3 <= ev_s2;
		end
	end
	// ------------------------------------------------------------
	// Per-timer count logic
	// ------------------------------------------------------------
	// In cascade the high byte takes run, clock and carry from the low
	assign run_eff[0] = mode[0].run;
	assign run_eff[1] = casc ? mode[0].run : mode[1].run;
	assign tick[0]    = tick_raw[0] & run_eff[0];
	assign tick[1]    = (casc ? tick_raw[0] : tick_raw[1]) & run_eff[1];
	assign step[0]    = tick[0];
	assign step[1]    = casc ? tick[0] & (cnt[0] == `TDC_CNT_MAX)
	                         : tick[1];
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_tmr
			assign clr_m[i] = casc ? m16 : (cnt[i] == cmp[i]);
			assign fire[i]  = tick[i] & ~mode[i].pwm & clr_m[i];
			assign lvl[i]   = mode[i].pwm ? (pwm_act[i] ^ mode[i].pol)
			                              : tff[i];
			always_comb begin
				case (csel[i])
					`TDC_CSEL_FALL: tick_raw[i] = ev_s3[i] & ~ev_s2[i];
					`TDC_CSEL_RISE: tick_raw[i] = ~ev_s3[i] & ev_s2[i];
					default: tick_raw[i] = (pre[i] & div_mask(csel[i], 1'(i)))
					                    == div_mask(csel[i], 1'(i));
				endcase
			end
			always_ff @(posedge mclk) begin
				if (!rstn || !run_eff[i]) begin
					pre[i] <= '0;
				end else begin
					pre[i] <= pre[i] + PRE_W'(1);
				end
			end
			always_ff @(posedge mclk) begin
				if (!rstn || !run_eff[i]) begin
					cnt[i] <= 8'h00;
				end else if (fire[i]) begin
					cnt[i] <= 8'h00;
				end else if (step[i]) begin
					cnt[i] <= cnt[i] + 8'h01;
				end
			end
			always_ff @(posedge mclk) begin
				if (!rstn) begin
					match_irq[i] <= 1'b0;
				end else begin
					match_irq[i] <= fire[i];
				end
			end
			// A software preset beats a toggle landing in the same cycle
			always_ff @(posedge mclk) begin
				if (!rstn) begin
					tff[i] <= 1'b0;
				end else if (wr_mode[i] && pwdata[`TDC_SET_BIT]
				             && !pwdata[`TDC_CLR_BIT]) begin
					tff[i] <= 1'b1;
				end else if (wr_mode[i] && pwdata[`TDC_CLR_BIT]
				             && !pwdata[`TDC_SET_BIT]) begin
					tff[i] <= 1'b0;
				end else if (fire[i] && mode[i].pol) begin
					tff[i] <= ~tff[i];
				end
			end
			always_ff @(posedge mclk) begin
				if (!rstn || !run_eff[i] || !mode[i].pwm) begin
					pwm_act[i] <= 1'b0;
				end else if (tick[i] && cnt[i] == `TDC_CNT_MAX) begin
					pwm_act[i] <= 1'b1;
				end else if (tick[i] && cnt[i] == cmp[i]) begin
					pwm_act[i] <= 1'b0;
				end
			end
			property p_stop_clears;
				!run_eff[i] |=> cnt[i] == 8'h00;
			endproperty
			a_stop_clears: assert property (p_stop_clears)
				else $error("counter not cleared while stopped");
			sequence s_match;
				run_eff[i] && tick[i] && !mode[i].pwm && clr_m[i];
			endsequence
			property p_match_clear;
				s_match |=> cnt[i] == 8'h00 && match_irq[i];
			endproperty
			a_match_clear: assert property (p_match_clear)
				else $error("match did not clear counter and raise irq");
			property p_irq_cause;
				match_irq[i] |-> $past(tick[i]) && $past(clr_m[i])
				                 && !$past(mode[i].pwm);
			endproperty
			a_irq_cause: assert property (p_irq_cause)
				else $error("interrupt without a compare match");
			property p_toggle;
				s_match ##0 (mode[i].pol && !wr_mode[i])
				|=> tff[i] != $past(tff[i]);
			endproperty
			a_toggle: assert property (p_toggle)
				else $error("output flip-flop did not invert on match");
			property p_preset;
				wr_mode[i] && pwdata[3:2] == 2'b10 ##1 !wr_mode[i] [*2]
				|-> tff[i] || $past(fire[i] && mode[i].pol);
			endproperty
			a_preset: assert property (p_preset)
				else $error("preset did not set output flip-flop");
			sequence s_pwm_idle;
				(mode[i].pwm && !run_eff[i] && $stable(mode[i])) [*2];
			endsequence
			property p_pwm_idle;
				s_pwm_idle |=> lvl[i] == mode[i].pol;
			endproperty
			a_pwm_idle: assert property (p_pwm_idle)
				else $error("stopped PWM output not inactive");
			property p_pin_drive;
				mode[i].oe && $stable(mode[i].oe) |-> ##1
				port_out[2+i] == $past(lvl[i]);
			endproperty
			a_pin_drive: assert property (p_pin_drive)
				else $error("timer pin not driven by flip-flop");
		end
	endgenerate
	// ------------------------------------------------------------
	// Port pins
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			port_out  <= 6'h00;
			port_oe_n <= 6'h3F;
		end else begin
			port_out  <= plat[5:0];
			port_oe_n <= pdir[5:0];
			if (mode[0].oe) begin
				port_out[2] <= lvl[0];
			end
			if (mode[1].oe) begin
				port_out[3] <= lvl[1];
			end
		end
	end
	property p_preset_reads_zero;
		setup && !pwrite && (paddr == `TDC_MODE0_ADDR
		|| paddr == `TDC_MODE1_ADDR) |=> prdata[3:2] == 2'b00;
	endproperty
	a_preset_reads_zero: assert property (p_preset_reads_zero)
		else $error("preset bits read back nonzero");
	property p_dir_pin;
		wr_go && paddr == `TDC_PDIR_ADDR |=> ##1
		port_oe_n == $past(pwdata[5:0], 2);
	endproperty
	a_dir_pin: assert property (p_dir_pin)
		else $error("direction write not seen on pin enables");
	property p_cascade_irq;
		casc && run_eff[0] && tick[0] && !mode[0].pwm && !mode[1].pwm
		&& m16 |=> match_irq == 2'b11 && cnt[0] == 8'h00;
	endproperty
	a_cascade_irq: assert property (p_cascade_irq)
		else $error("cascade match did not raise both interrupts");
endmodule

// ---- tdc_regs.svh ----
// Register addresses, field positions and reset values of the timer pair
`ifndef TDC_REGS_SVH
`define TDC_REGS_SVH
`define TDC_MODE0_ADDR 16'hFF70
`define TDC_MODE1_ADDR 16'hFF78
`define TDC_CSEL0_ADDR 16'hFF74
`define TDC_CSEL1_ADDR 16'hFF7C
`define TDC_CMP0_ADDR  16'hFF60
`define TDC_CMP1_ADDR  16'hFF64
`define TDC_CNT0_ADDR  16'hFF68
`define TDC_CNT1_ADDR  16'hFF6C
`define TDC_PDIR_ADDR  16'hFF80
`define TDC_PLAT_ADDR  16'hFF84
`define TDC_RUN_BIT    7
`define TDC_PWM_BIT    6
`define TDC_CASC_BIT   4
`define TDC_SET_BIT    3
`define TDC_CLR_BIT    2
`define TDC_POL_BIT    1
`define TDC_OE_BIT     0
`define TDC_MODE_RST   5'h00
`define TDC_CSEL_RST   3'h0
`define TDC_CMP_RST    8'h00
`define TDC_PDIR_RST   8'hFF
`define TDC_PLAT_RST   8'h00
`define TDC_PDIR_ONES  8'hC0
`define TDC_CSEL_FALL  3'h0
`define TDC_CSEL_RISE  3'h1
`define TDC_CNT_MAX    8'hFF
`endif

// ---- tdc_pkg.sv ----
// Types shared by the timer pair
package tdc_pkg;
	typedef struct packed {
		logic run;
		logic pwm;
		logic casc;
		logic pol;
		logic oe;
	} tdc_mode_t;
	typedef logic [7:0] tdc_byte_t;
endpackage

// ---- tdc_pin_model.sv ----
// Far-side model of the port pins: event source and pin level resolution
`timescale 1ns/1ps

module tdc_pin_model (
	input  wire logic       mclk,
	input  wire logic [5:0] port_out,
	input  wire logic [5:0] port_oe_n,
	output logic      [5:0] port_in
);
	logic [5:0] ev_lvl;
	logic [5:0] churn;

	initial begin
		ev_lvl = 6'h00;
		churn = 6'h2A;
	end

	// Floating pins churn so a stale value never passes for a real one
	always @(posedge mclk) begin
		churn <= ~churn;
	end

	// Driven pins read back; released event pins carry the source
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (port_oe_n[i] == 1'b0) begin
				port_in[i] = port_out[i];
			end else if (i == 2 || i == 3) begin
				port_in[i] = ev_lvl[i];
			end else begin
				port_in[i] = churn[i];
			end
		end
	end

	// Each level is held well past the synchroniser depth
	task automatic pulse(input int pin, input int n, input int half);
		repeat (n) begin
			@(posedge mclk);
			ev_lvl[pin] <= 1'b1;
			repeat (half) @(posedge mclk);
			ev_lvl[pin] <= 1'b0;
			repeat (half) @(posedge mclk);
		end
	endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the timer pair
`timescale 1ns/1ps
`include "tdc_regs.svh"

module tb_top;
	logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0]  port_in, port_out, port_oe_n;
	logic [1:0]  match_irq;
	logic [7:0]  probes, rd, m;
	int          n_mismatch, num_checks, c, d, t;
	logic [15:0] csel_a[2] = '{`TDC_CSEL0_ADDR, `TDC_CSEL1_ADDR};
	logic [15:0] cmp_a[2]  = '{`TDC_CMP0_ADDR, `TDC_CMP1_ADDR};
	logic [15:0] mode_a[2] = '{`TDC_MODE0_ADDR, `TDC_MODE1_ADDR};
	int          tt[4] = '{0, 0, 1, 0};
	logic [7:0]  cm[4] = '{8'h00, 8'h03, 8'h03, 8'h07};
	int          ex[4] = '{40, 10, 5, 5};

	assign probes = {match_irq, port_out};

	tdc_timer #(.PRE_W(11)) i_tdc_timer (.mclk(mclk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_in(port_in), .port_out(port_out),
		.port_oe_n(port_oe_n), .match_irq(match_irq));

	tdc_pin_model i_tdc_pin_model (.mclk(mclk), .port_out(port_out),
		.port_oe_n(port_oe_n), .port_in(port_in));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ----------------------------------------
	// Reporting and compares
	// ----------------------------------------
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task chk_val(input logic [7:0] got, input logic [7:0] exp, input string s);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h", $time, s, got);
		end
	endtask

	task chk_cnt(input int got, input int exp, input string s);
		num_checks++;
		if (got != exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %0d", $time, s, got);
		end
	endtask

	// ----------------------------------------
	// Bus and timing helpers
	// ----------------------------------------
	task xfer(input logic [15:0] a, input logic w, input logic [7:0] v);
		int i;
		i = 0;
		@(posedge mclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, v};
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: no bus answer", $time);
			report_and_stop();
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [15:0] a, input logic [7:0] v);
		xfer(a, 1'b1, v);
	endtask

	task rdchk(input logic [15:0] a, input logic [7:0] exp);
		xfer(a, 1'b0, 8'h00);
		chk_val(rd, exp, "read");
	endtask

	task wt(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Counts high cycles of one probe and irq disagreements
	task cnt_hi(input int idx, input int n);
		c = 0;
		d = 0;
		repeat (n) begin
			@(posedge mclk);
			c += int'(probes[idx] === 1'b1);
			d += int'(match_irq[0] !== match_irq[1]);
		end
	endtask

	task done(input string s);
		$display("test %s finished, mismatches %0d", s, n_mismatch);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		n_mismatch = 0;
		num_checks = 0;
		wt(8);
		rstn <= 1'b1;
		chk_val({2'h0, port_oe_n}, 8'h3F, "oe_n");
		rdchk(`TDC_MODE0_ADDR, 8'h00);
		rdchk(`TDC_MODE1_ADDR, 8'h00);
		rdchk(`TDC_PDIR_ADDR, 8'hFF);
		wr(`TDC_MODE0_ADDR, 8'hF3);
		rdchk(`TDC_MODE0_ADDR, 8'hC3);
		wr(`TDC_MODE1_ADDR, 8'hF3);
		rdchk(`TDC_MODE1_ADDR, 8'hD3);
		wr(`TDC_MODE0_ADDR, 8'h00);
		wr(`TDC_MODE1_ADDR, 8'h00);
		wr(`TDC_PDIR_ADDR, 8'h00);
		rdchk(`TDC_PDIR_ADDR, 8'hC0);
		chk_val({2'h0, port_oe_n}, 8'h00, "oe_n");
		wr(`TDC_CSEL1_ADDR, 8'h05);
		rdchk(`TDC_CSEL1_ADDR, 8'h05);
		wr(`TDC_CMP1_ADDR, 8'hA5);
		rdchk(`TDC_CMP1_ADDR, 8'hA5);
		done("registers");
		wr(`TDC_PLAT_ADDR, 8'h00);
		wr(`TDC_PDIR_ADDR, 8'hFB);
		wr(`TDC_MODE0_ADDR, 8'h09);
		wt(3);
		chk_val({7'h0, port_out[2]}, 8'h01, "pin");
		rdchk(`TDC_MODE0_ADDR, 8'h01);
		wr(`TDC_MODE0_ADDR, 8'h05);
		wt(3);
		chk_val({7'h0, port_out[2]}, 8'h00, "pin");
		wr(`TDC_MODE0_ADDR, 8'h00);
		wr(`TDC_PLAT_ADDR, 8'h04);
		wt(3);
		chk_val({7'h0, port_out[2]}, 8'h01, "pin");
		wr(`TDC_PLAT_ADDR, 8'h00);
		wr(`TDC_PDIR_ADDR, 8'hF3);
		wr(`TDC_MODE1_ADDR, 8'h09);
		wt(3);
		chk_val({7'h0, port_out[3]}, 8'h01, "pin1");
		wr(`TDC_MODE1_ADDR, 8'h04);
		wt(3);
		chk_val({7'h0, port_out[3]}, 8'h00, "pin1");
		done("preset");
		for (int k = 0; k < 4; k++) begin
			t = tt[k];
			wr(csel_a[t], 8'h02);
			wr(cmp_a[t], cm[k]);
			wr(mode_a[t], 8'h80);
			wt(4);
			cnt_hi(6 + t, 40);
			chk_cnt(c, ex[k], "irq count");
			wr(mode_a[t], 8'h00);
		end
		rdchk(`TDC_CNT0_ADDR, 8'h00);
		done("interval");
		wr(`TDC_CMP0_ADDR, 8'h03);
		wr(`TDC_MODE0_ADDR, 8'h83);
		wt(4);
		cnt_hi(2, 40);
		chk_cnt(c, 20, "square high");
		wr(`TDC_MODE0_ADDR, 8'h05);
		wr(`TDC_MODE0_ADDR, 8'h81);
		wt(4);
		cnt_hi(2, 40);
		chk_cnt(c, 0, "no toggle");
		done("square");
		wr(`TDC_CMP0_ADDR, 8'h40);
		for (int p = 0; p < 2; p++) begin
			m = (p == 1) ? 8'h43 : 8'h41;
			wr(`TDC_MODE0_ADDR, m);
			wt(3);
			chk_val({7'h0, port_out[2]}, 8'(p), "idle pwm");
			wr(`TDC_MODE0_ADDR, m | 8'h80);
			wt(300);
			cnt_hi(2, 256);
			chk_cnt(c, (p == 1) ? 191 : 65, "pwm");
			wr(`TDC_MODE0_ADDR, m);
			wt(3);
			chk_val({7'h0, port_out[2]}, 8'(p), "stop pwm");
		end
		wr(`TDC_MODE0_ADDR, 8'h00);
		done("pwm");
		wr(`TDC_PDIR_ADDR, 8'hFF);
		wr(`TDC_CMP0_ADDR, 8'hFF);
		for (int s = 0; s < 2; s++) begin
			wr(`TDC_CSEL0_ADDR, 8'(s));
			wr(`TDC_MODE0_ADDR, 8'h80);
			i_tdc_pin_model.pulse(2, 5, 4);
			wt(6);
			rdchk(`TDC_CNT0_ADDR, 8'h05);
			wr(`TDC_MODE0_ADDR, 8'h00);
		end
		done("event");
		wr(`TDC_CSEL0_ADDR, 8'h02);
		wr(`TDC_CMP0_ADDR, 8'h02);
		wr(`TDC_CMP1_ADDR, 8'h01);
		wr(`TDC_MODE1_ADDR, 8'h90);
		wr(`TDC_MODE0_ADDR, 8'h80);
		wt(4);
		cnt_hi(6, 518);
		chk_cnt(c, 2, "cascade irq0");
		chk_cnt(d, 0, "irq pairing");
		cnt_hi(7, 518);
		chk_cnt(c, 2, "cascade irq1");
		wr(`TDC_MODE0_ADDR, 8'h00);
		rdchk(`TDC_CNT0_ADDR, 8'h00);
		rdchk(`TDC_CNT1_ADDR, 8'h00);
		wr(`TDC_MODE1_ADDR, 8'h00);
		done("cascade");
		wr(`TDC_PDIR_ADDR, 8'h00);
		wr(`TDC_MODE1_ADDR, 8'h83);
		rstn <= 1'b0;
		wt(2);
		rstn <= 1'b1;
		chk_val({2'h0, port_oe_n}, 8'h3F, "oe_n");
		rdchk(`TDC_PDIR_ADDR, 8'hFF);
		rdchk(`TDC_MODE1_ADDR, 8'h00);
		done("reset");
		xfer(16'hFF90, 1'b0, 8'h00);
		chk_val(rd, 8'h00, "unmapped data");
		chk_val({7'h0, err}, 8'h01, "unmapped error");
		done("unmapped");
		report_and_stop();
	end
endmodule
